// ### hw/ita_entry_adjust.sv
// per-entry cache-hit and wait-state adjustment, combinational
`timescale 1ns/100ps
module ita_entry_adjust
    import ita_pkg::*;
(
    input  ita_entry_t        ent,        // table entry
    input  logic [WAIT_W-1:0] waitStates, // wait clocks per bus cycle
    output ita_adj_t          adj,        // adjusted entry
    output logic [RW_W-1:0]   extReads,   // external read cycles started
    output logic [RW_W-1:0]   extWrites   // external write cycles started
);

    logic             hitEff;
    logic [ADJ_W-1:0] w;
    logic [ADJ_W-1:0] readWait;
    logic [ADJ_W-1:0] writeWait;
    logic [ADJ_W-1:0] tailT;
    logic [ADJ_W-1:0] table_cached_count;

    always_comb
    begin
        w = ADJ_W'(waitStates);
        tailT = ADJ_W'(ent.tail);
        table_cached_count = ADJ_W'(ent.tableCachedCount);
        readWait = ADJ_W'(ent.reads) * w;
        writeWait = ADJ_W'(ent.writes) * w;
        // only fetch-type ea entries shrink; locked cycles always miss
        hitEff = ent.cacheHit && !ent.rmw && ent.kind == ITA_EA_FETCH
                 && ent.reads != NO_ACCESS;
        adj.kind = ent.kind;
        adj.last = ent.last;
        adj.head = ADJ_W'(ent.head);
        adj.tail = tailT;
        adj.cachedCycleCount = table_cached_count;
        // indirect modes use the same one-read reduction
        if (hitEff && ent.tail == TAIL_ONE)
        begin
            adj.tail = '0;
            adj.cachedCycleCount = table_cached_count - HIT_TAIL_KEPT;
        end
        else if (hitEff && ent.tail > TAIL_ONE)
        begin
            adj.tail = HIT_TAIL_KEPT;
            adj.cachedCycleCount = table_cached_count - (tailT - HIT_TAIL_KEPT);
        end
        case (ent.kind)
            ITA_EA_FETCH:
            begin
                // a hit read costs no bus time, so no wait states
                if (!hitEff && ent.reads != NO_ACCESS && ent.memIndirect)
                begin
                    adj.tail = tailT + w;
                    adj.cachedCycleCount = table_cached_count + INDIRECT_READS * w;
                end
                else if (!hitEff && ent.reads != NO_ACCESS)
                begin
                    adj.tail = tailT + w;
                    adj.cachedCycleCount = table_cached_count + w;
                end
            end
            ITA_EA_CALC:
            begin
                if (ent.memIndirect && ent.reads != NO_ACCESS)
                    adj.cachedCycleCount = table_cached_count + w;
            end
            ITA_OP:
            begin
                adj.cachedCycleCount = table_cached_count + readWait + writeWait;
                if (ent.writes != NO_ACCESS)
                    adj.tail = tailT + w;
            end
            default:
            begin
                adj.tail = tailT;
            end
        endcase
        extReads = (ent.cacheHit && !ent.rmw) ? NO_ACCESS : ent.reads;
        extWrites = ent.writes;
    end

endmodule : ita_entry_adjust

// ### hw/ita_overlap_accum.sv
// running total with head/tail overlap between successive entries
`timescale 1ns/100ps
module ita_overlap_accum
    import ita_pkg::*;
(
    input  wire logic               clk,      // 200 MHz clock
    input  wire logic               rstN,     // synchronised reset, low
    input  wire logic               inValid,  // entry strobe
    input  wire logic               inLast,   // entry closes sequence
    input  wire logic [ADJ_W-1:0]   inHead,   // entry head
    input  wire logic [ADJ_W-1:0]   inTail,   // entry tail
    input  wire logic [ADJ_W-1:0]   inCount,  // entry cached count
    output logic signed [SUM_W-1:0] sum,      // sequence total
    output logic                    sumValid  // one-cycle total strobe
);

    logic signed [SUM_W-1:0] run_reg;
    logic [ADJ_W-1:0]        prevTail_reg;
    logic                    started_reg;
    logic [ADJ_W-1:0]        overlap;
    logic signed [SUM_W-1:0] run_next;

    always_comb
    begin
        overlap = '0;
        if (started_reg)
            overlap = (inHead < prevTail_reg) ? inHead : prevTail_reg;
        // may go negative when a fetch is fully overlapped
        run_next = run_reg + SUM_W'(inCount) - SUM_W'(overlap);
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            run_reg <= '0;
            prevTail_reg <= '0;
            started_reg <= 1'b0;
        end
        else if (inValid)
        begin
            run_reg <= inLast ? '0 : run_next;
            prevTail_reg <= inTail;
            started_reg <= !inLast;
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            sum <= '0;
            sumValid <= 1'b0;
        end
        else
        begin
            sumValid <= inValid && inLast;
            if (inValid && inLast)
                sum <= run_next;
        end
    end

endmodule : ita_overlap_accum

// ### hw/ita_pkg.sv
// shared widths, constants and carrier types for the timing adjuster
package ita_pkg;

    localparam int CNT_W = 8;   // table head, tail and count width
    localparam int WAIT_W = 4;  // wait states per bus cycle, in clocks
    localparam int RW_W = 3;    // operand reads or writes per entry
    localparam int ADJ_W = 10;  // adjusted head, tail and count width
    localparam int SUM_W = 16;  // signed running total width
    localparam int SEQ_W = 12;  // per-sequence bus cycle counters

    localparam logic [CNT_W-1:0] TAIL_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] TAIL_ONE = 8'h01;
    localparam logic [ADJ_W-1:0] HIT_TAIL_KEPT = 10'h001;
    localparam logic [ADJ_W-1:0] INDIRECT_READS = 10'h002;
    localparam logic [RW_W-1:0] NO_ACCESS = 3'h0;
    localparam logic [1:0] SYNC_STAGES = 2'h2;

    typedef enum logic [1:0]
    {
        ITA_EA_FETCH,
        ITA_EA_CALC,
        ITA_OP
    } ita_kind_t;

    typedef struct packed
    {
        ita_kind_t        kind;
        logic             memIndirect;
        logic             rmw;
        logic             cacheHit;
        logic             last;
        logic [CNT_W-1:0] head;
        logic [CNT_W-1:0] tail;
        logic [CNT_W-1:0] tableCachedCount;
        logic [RW_W-1:0]  reads;
        logic [RW_W-1:0]  writes;
    } ita_entry_t;

    typedef struct packed
    {
        ita_kind_t        kind;
        logic             last;
        logic [ADJ_W-1:0] head;
        logic [ADJ_W-1:0] tail;
        logic [ADJ_W-1:0] cachedCycleCount;
    } ita_adj_t;

endpackage : ita_pkg

// ### hw/ita_timing_adjust.sv
// instruction timing adjuster: cache hits, wait states and overlap total
//
// How it works
// - a read hitting the data cache starts no external bus cycle
// - every operand write starts an external cycle; cache writes through
// - fetch-ea hit: tail 0 unchanged; 1 to 0, count-1; else 1, count-(tail-1)
// - memory-indirect fetch ea hit is reduced as one single read
// - operation entries get no cache-hit reduction
// - locked read-modify-write cycles always count as cache misses
// - direct fetch ea with a read: waits added to tail and count
// - indirect calculate ea, one read: waits added to count only
// - indirect fetch ea, two reads: count gets two waits, tail one
// - operation with one read: waits added to count only
// - operation with several reads: count gets all their waits
// - operation with a write: waits added to tail and count
// - several writes: tail gets one write's waits, count all of them
// - total sums counts, each less min(own head, previous tail)
// - table input assumes zero waits, aligned, 32-bit bus, no data cache
`timescale 1ns/100ps
module ita_timing_adjust
    import ita_pkg::*;
(
    input  wire logic               clk,           // 200 MHz clock
    input  wire logic               nrst,          // async reset, low
    input  wire logic               entValid,      // table entry strobe
    input  ita_entry_t              ent,           // table entry
    input  wire logic [WAIT_W-1:0]  waitStates,    // wait clocks per cycle
    output logic                    adjValid,      // adjusted entry strobe
    output ita_adj_t                adjOut,        // adjusted entry
    output logic [RW_W-1:0]         busReads,      // entry external reads
    output logic [RW_W-1:0]         busWrites,     // entry external writes
    output logic                    totalValid,    // sequence done strobe
    output logic signed [SUM_W-1:0] totalCycles,   // adjusted total
    output logic signed [SUM_W-1:0] baseCycles,    // unadjusted total
    output logic [SEQ_W-1:0]        seqBusReads,   // reads in sequence
    output logic [SEQ_W-1:0]        seqBusWrites,  // writes in sequence
    output logic [SEQ_W-1:0]        seqCacheReads, // reads served by cache
    output logic                    totalNegative  // total below zero
);

    logic [SYNC_STAGES-1:0] rstSync_reg;
    logic                   rstN;

    // release synchronised; assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rstSync_reg <= '0;
        else
            rstSync_reg <= {rstSync_reg[SYNC_STAGES-2:0], 1'b1};
    end

    assign rstN = rstSync_reg[SYNC_STAGES-1];

    // wait count frozen for the whole sequence so entries agree
    logic [WAIT_W-1:0] seqWait_reg;
    logic              inSeq_reg;
    logic [WAIT_W-1:0] useWait;

    assign useWait = inSeq_reg ? seqWait_reg : waitStates;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            seqWait_reg <= '0;
            inSeq_reg <= 1'b0;
        end
        else if (entValid)
        begin
            seqWait_reg <= useWait;
            inSeq_reg <= !ent.last;
        end
    end

    ita_adj_t        adjComb;
    logic [RW_W-1:0] extReads;
    logic [RW_W-1:0] extWrites;

    ita_entry_adjust u_adjust
    (
        .ent        (ent),
        .waitStates (useWait),
        .adj        (adjComb),
        .extReads   (extReads),
        .extWrites  (extWrites)
    );

    // baseline copy keeps the raw table figures
    ita_adj_t base_reg;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            adjValid <= 1'b0;
            adjOut <= '0;
            base_reg <= '0;
            busReads <= '0;
            busWrites <= '0;
        end
        else
        begin
            adjValid <= entValid;
            if (entValid)
            begin
                adjOut <= adjComb;
                base_reg.kind <= ent.kind;
                base_reg.last <= ent.last;
                base_reg.head <= ADJ_W'(ent.head);
                base_reg.tail <= ADJ_W'(ent.tail);
                base_reg.cachedCycleCount <= ADJ_W'(ent.tableCachedCount);
                busReads <= extReads;
                busWrites <= extWrites;
            end
        end
    end

    logic signed [SUM_W-1:0] adjSum;
    logic                    adjSumValid;
    logic signed [SUM_W-1:0] baseSum;

    // adjusted totalling sees only already adjusted entries; base totalling sees the raw copy
    ita_overlap_accum u_accAdj
    (
        .clk      (clk),
        .rstN     (rstN),
        .inValid  (adjValid),
        .inLast   (adjOut.last),
        .inHead   (adjOut.head),
        .inTail   (adjOut.tail),
        .inCount  (adjOut.cachedCycleCount),
        .sum      (adjSum),
        .sumValid (adjSumValid)
    );

    ita_overlap_accum u_accBase
    (
        .clk      (clk),
        .rstN     (rstN),
        .inValid  (adjValid),
        .inLast   (base_reg.last),
        .inHead   (base_reg.head),
        .inTail   (base_reg.tail),
        .inCount  (base_reg.cachedCycleCount),
        .sum      (baseSum),
        .sumValid ()
    );

    // bus traffic tallies for the current sequence
    logic [SEQ_W-1:0] rdRun_reg;
    logic [SEQ_W-1:0] wrRun_reg;
    logic [SEQ_W-1:0] hitRun_reg;
    logic [SEQ_W-1:0] rdRun_next;
    logic [SEQ_W-1:0] wrRun_next;
    logic [SEQ_W-1:0] hitRun_next;
    logic [RW_W-1:0]  hitReads_reg;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            hitReads_reg <= '0;
        else if (entValid)
            hitReads_reg <= ent.reads - extReads;
    end

    always_comb
    begin
        rdRun_next = rdRun_reg + SEQ_W'(busReads);
        wrRun_next = wrRun_reg + SEQ_W'(busWrites);
        hitRun_next = hitRun_reg + SEQ_W'(hitReads_reg);
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdRun_reg <= '0;
            wrRun_reg <= '0;
            hitRun_reg <= '0;
        end
        else if (adjValid && adjOut.last)
        begin
            rdRun_reg <= '0;
            wrRun_reg <= '0;
            hitRun_reg <= '0;
        end
        else if (adjValid)
        begin
            rdRun_reg <= rdRun_next;
            wrRun_reg <= wrRun_next;
            hitRun_reg <= hitRun_next;
        end
    end

    // sequence tallies land with the totals, two cycles after last entry
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            seqBusReads <= '0;
            seqBusWrites <= '0;
            seqCacheReads <= '0;
        end
        else if (adjValid && adjOut.last)
        begin
            seqBusReads <= rdRun_next;
            seqBusWrites <= wrRun_next;
            seqCacheReads <= hitRun_next;
        end
    end

    assign totalValid = adjSumValid;
    assign totalCycles = adjSum;
    assign baseCycles = baseSum;

    // a negative total means inconsistent table input;
    // taken from the total flop so it lands with totalValid
    assign totalNegative = adjSum[SUM_W-1];

endmodule : ita_timing_adjust

// ### test/ita_mem_model.sv
// external memory stand-in that offers wait states per bus cycle
`timescale 1ns/100ps
module ita_mem_model
    import ita_pkg::*;
(
    input  wire logic              clk,        // clock
    input  wire logic [WAIT_W-1:0] cfgWaits,   // requested wait clocks
    output logic      [WAIT_W-1:0] waitStates  // wait clocks offered
);
    // memory timing only moves on an edge, never mid-cycle
    always_ff @(posedge clk)
    begin
        waitStates <= cfgWaits;
    end
endmodule : ita_mem_model

// ### test/ita_timing_adjust_tb.sv
// self-checking bench for the instruction timing adjuster
`timescale 1ns/100ps
module ita_timing_adjust_tb
    import ita_pkg::*;
;
    typedef struct packed
    {
        ita_adj_t        a;
        logic [RW_W-1:0] r;
        logic [RW_W-1:0] w;
    } ita_exp_t;
    typedef struct packed
    {
        logic signed [SUM_W-1:0] tot;
        logic signed [SUM_W-1:0] base;
        logic                    neg;
        logic [SEQ_W-1:0]        wr;
        logic [SEQ_W-1:0]        rd;
        logic [SEQ_W-1:0]        hit;
    } ita_tot_t;
    logic                    clk = 1'b0;
    logic                    nrst = 1'b0;
    logic                    entValid = 1'b0;
    ita_entry_t              ent = '0;
    logic [WAIT_W-1:0]       cfgWaits = 4'h0;
    logic [WAIT_W-1:0]       waitStates;
    logic                    adjValid;
    ita_adj_t                adjOut;
    logic [RW_W-1:0]         busReads;
    logic [RW_W-1:0]         busWrites;
    logic                    totalValid;
    logic                    totalNegative;
    logic signed [SUM_W-1:0] totalCycles;
    logic signed [SUM_W-1:0] baseCycles;
    logic [SEQ_W-1:0]        seqBusWrites;
    logic [SEQ_W-1:0]        seqBusReads;
    logic [SEQ_W-1:0]        seqCacheReads;
    int                      num_errors = 0;
    int                      comparisons = 0;
    ita_exp_t                expQ[$];
    ita_tot_t                totQ[$];

    always #2.5 clk = ~clk;

    ita_mem_model i_mem (.clk(clk), .cfgWaits(cfgWaits), .waitStates(waitStates));
    ita_timing_adjust i_dut (.clk(clk), .nrst(nrst), .entValid(entValid), .ent(ent),
        .waitStates(waitStates), .adjValid(adjValid), .adjOut(adjOut), .busReads(busReads),
        .busWrites(busWrites), .totalValid(totalValid), .totalCycles(totalCycles),
        .baseCycles(baseCycles), .seqBusReads(seqBusReads), .seqBusWrites(seqBusWrites),
        .seqCacheReads(seqCacheReads), .totalNegative(totalNegative));

    task err(input string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : err
    task chk_adj(input ita_exp_t got, input ita_exp_t exp);
        comparisons++;
        if (got !== exp)
            err($sformatf("entry got %h want %h", got, exp));
    endtask : chk_adj
    task chk_tot(input ita_tot_t got, input ita_tot_t exp);
        comparisons++;
        if (got !== exp)
            err($sformatf("total got %h want %h", got, exp));
    endtask : chk_tot

    // results are popped in order; a stray strobe is a mismatch
    always @(negedge clk)
    begin
        if (adjValid === 1'b1 && expQ.size() == 0)
            err("stray result");
        else if (adjValid === 1'b1)
            chk_adj({adjOut, busReads, busWrites}, expQ.pop_front());
        if (totalValid === 1'b1 && totQ.size() == 0)
            err("stray total");
        else if (totalValid === 1'b1)
            chk_tot({totalCycles, baseCycles, totalNegative, seqBusWrites, seqBusReads,
                seqCacheReads}, totQ.pop_front());
    end

    // flags: 8 indirect, 4 locked, 2 cache hit, 1 last
    function automatic ita_entry_t mk(ita_kind_t k, logic [3:0] f, logic [CNT_W-1:0] h, t,
        c, logic [RW_W-1:0] r, w);
        return '{k, f[3], f[2], f[1], f[0], h, t, c, r, w};
    endfunction : mk
    task put(input ita_entry_t e, input logic [ADJ_W-1:0] h, t, c, input logic [2:0] br);
        expQ.push_back({ita_adj_t'{e.kind, e.last, h, t, c}, br, e.writes});
        ent <= e;
        entValid <= 1'b1;
        @(posedge clk);
    endtask : put
    task cfg(input logic [WAIT_W-1:0] w);
        cfgWaits <= w;
        repeat (2) @(posedge clk);
    endtask : cfg
    task close(input logic signed [SUM_W-1:0] tot, base, input logic neg,
        input logic [SEQ_W-1:0] wr, rd, hit, input string name);
        totQ.push_back({tot, base, neg, wr, rd, hit});
        entValid <= 1'b0;
        repeat (4) @(posedge clk);
        if (expQ.size() != 0 || totQ.size() != 0)
            err("result missing");
        $display("test %s done", name);
    endtask : close

    task t_hits;
        cfg(4'h0);
        put(mk(ITA_EA_FETCH, 4'h2, 8'h02, 8'h02, 8'h04, 3'h1, 3'h0), 10'h2, 10'h1, 10'h3, 3'h0);
        put(mk(ITA_OP, 4'h2, 8'h00, 8'h00, 8'h02, 3'h1, 3'h0), 10'h0, 10'h0, 10'h2, 3'h0);
        put(mk(ITA_EA_FETCH, 4'ha, 8'h04, 8'h00, 8'h0a, 3'h2, 3'h0), 10'h4, 10'h0, 10'ha, 3'h0);
        put(mk(ITA_OP, 4'h0, 8'h00, 8'h01, 8'h03, 3'h0, 3'h1), 10'h0, 10'h1, 10'h3, 3'h0);
        put(mk(ITA_EA_FETCH, 4'h2, 8'h01, 8'h01, 8'h03, 3'h1, 3'h0), 10'h1, 10'h0, 10'h2, 3'h0);
        put(mk(ITA_OP, 4'h0, 8'h02, 8'h00, 8'h04, 3'h0, 3'h1), 10'h2, 10'h0, 10'h4, 3'h0);
        put(mk(ITA_EA_CALC, 4'h0, 8'h00, 8'h00, 8'h02, 3'h0, 3'h0), 10'h0, 10'h0, 10'h2, 3'h0);
        put(mk(ITA_OP, 4'h7, 8'h00, 8'h00, 8'h0c, 3'h1, 3'h1), 10'h0, 10'h0, 10'hc, 3'h1);
        close(16'sd37, 16'sd38, 1'b0, 12'h003, 12'h001, 12'h005, "cache hits");
    endtask : t_hits

    task t_waits;
        cfg(4'h2);
        put(mk(ITA_EA_FETCH, 4'h0, 8'h04, 8'h00, 8'h06, 3'h1, 3'h0), 10'h4, 10'h2, 10'h8, 3'h1);
        put(mk(ITA_OP, 4'h0, 8'h04, 8'h00, 8'h08, 3'h0, 3'h1), 10'h4, 10'h2, 10'ha, 3'h0);
        put(mk(ITA_EA_FETCH, 4'h8, 8'h04, 8'h00, 8'h0c, 3'h2, 3'h0), 10'h4, 10'h2, 10'h10, 3'h2);
        put(mk(ITA_OP, 4'h0, 8'h00, 8'h01, 8'h03, 3'h0, 3'h1), 10'h0, 10'h3, 10'h5, 3'h0);
        put(mk(ITA_EA_CALC, 4'h0, 8'h0a, 8'h00, 8'h04, 3'h0, 3'h0), 10'ha, 10'h0, 10'h4, 3'h0);
        put(mk(ITA_OP, 4'h0, 8'h06, 8'h00, 8'h0e, 3'h1, 3'h1), 10'h6, 10'h2, 10'h12, 3'h1);
        put(mk(ITA_EA_CALC, 4'h0, 8'h0e, 8'h00, 8'h08, 3'h0, 3'h0), 10'he, 10'h0, 10'h8, 3'h0);
        put(mk(ITA_OP, 4'h0, 8'h06, 8'h00, 8'h0e, 3'h2, 3'h0), 10'h6, 10'h0, 10'h12, 3'h2);
        put(mk(ITA_EA_CALC, 4'h8, 8'h06, 8'h00, 8'h0c, 3'h1, 3'h0), 10'h6, 10'h0, 10'he, 3'h1);
        put(mk(ITA_OP, 4'h1, 8'h02, 8'h00, 8'h18, 3'h4, 3'h0), 10'h2, 10'h0, 10'h20, 3'h4);
        close(16'sd124, 16'sd104, 1'b0, 12'h003, 12'h00b, 12'h000, "wait states");
    endtask : t_waits

    task t_writes;
        cfg(4'h1);
        put(mk(ITA_OP, 4'h1, 8'h00, 8'h01, 8'h03, 3'h0, 3'h3), 10'h0, 10'h2, 10'h6, 3'h0);
        close(16'sd6, 16'sd3, 1'b0, 12'h003, 12'h000, 12'h000, "several writes");
        cfg(4'h0);
        put(mk(ITA_OP, 4'h0, 8'h00, 8'h06, 8'h01, 3'h0, 3'h0), 10'h0, 10'h6, 10'h1, 3'h0);
        put(mk(ITA_EA_CALC, 4'h1, 8'h06, 8'h00, 8'h04, 3'h0, 3'h0), 10'h6, 10'h0, 10'h4, 3'h0);
        close(-16'sd1, -16'sd1, 1'b1, 12'h000, 12'h000, 12'h000, "negative total");
    endtask : t_writes

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #100000;
        err("run timed out");
        tally_and_finish;
    end

    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_hits;
        t_waits;
        t_writes;
        tally_and_finish;
    end
endmodule : ita_timing_adjust_tb

bind ita_timing_adjust ita_timing_monitor i_mon (.clk(clk), .nrst(nrst), .entValid(entValid),
    .ent(ent), .waitStates(waitStates), .adjValid(adjValid), .adjOut(adjOut),
    .busReads(busReads), .busWrites(busWrites), .totalValid(totalValid),
    .totalCycles(totalCycles), .totalNegative(totalNegative));

// ### test/ita_timing_monitor.sv
// assertion checker for the timing adjuster ports
`timescale 1ns/100ps
module ita_timing_monitor
    import ita_pkg::*;
(
    input wire logic                    clk,           // clock
    input wire logic                    nrst,          // reset, low
    input wire logic                    entValid,      // entry strobe
    input ita_entry_t                   ent,           // entry
    input wire logic [WAIT_W-1:0]       waitStates,    // wait clocks
    input wire logic                    adjValid,      // adjusted strobe
    input ita_adj_t                     adjOut,        // adjusted entry
    input wire logic [RW_W-1:0]         busReads,      // external reads
    input wire logic [RW_W-1:0]         busWrites,     // external writes
    input wire logic                    totalValid,    // total strobe
    input wire logic signed [SUM_W-1:0] totalCycles,   // total
    input wire logic                    totalNegative  // sign flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_last_in;
        entValid && ent.last;
    endsequence
    sequence s_read_hit;
        entValid && ent.cacheHit && !ent.rmw;
    endsequence
    // direct fetch miss; waits assumed steady within a sequence
    sequence s_direct_miss;
        entValid && ent.kind == ITA_EA_FETCH && !ent.memIndirect && ent.reads != 3'h0
            && !ent.cacheHit;
    endsequence

    property p_adj_pulse;
        entValid |=> adjValid;
    endproperty
    a_adj_pulse: assert property (p_adj_pulse) else $error("entry gave no result");
    property p_adj_cause;
        adjValid |-> $past(entValid);
    endproperty
    a_adj_cause: assert property (p_adj_cause) else $error("result without entry");
    property p_total_after;
        s_last_in |-> ##2 totalValid;
    endproperty
    a_total_after: assert property (p_total_after) else $error("total late");
    property p_total_cause;
        totalValid |-> $past(entValid, 2) && $past(ent.last, 2);
    endproperty
    a_total_cause: assert property (p_total_cause) else $error("total uncaused");
    property p_hit_no_read;
        s_read_hit |=> busReads == 3'h0;
    endproperty
    a_hit_no_read: assert property (p_hit_no_read) else $error("hit went to bus");
    property p_writes_out;
        entValid |=> busWrites == $past(ent.writes);
    endproperty
    a_writes_out: assert property (p_writes_out) else $error("write count wrong");
    property p_rmw_reads;
        entValid && ent.rmw |=> busReads == $past(ent.reads);
    endproperty
    a_rmw_reads: assert property (p_rmw_reads) else $error("locked read skipped");
    property p_head_kept;
        entValid |=> adjOut.head == 10'($past(ent.head));
    endproperty
    a_head_kept: assert property (p_head_kept) else $error("head changed");
    property p_direct_wait;
        s_direct_miss |=> adjOut.tail == 10'($past(ent.tail)) + 10'($past(waitStates))
            && adjOut.cachedCycleCount
            == 10'($past(ent.tableCachedCount)) + 10'($past(waitStates));
    endproperty
    a_direct_wait: assert property (p_direct_wait) else $error("direct wait wrong");
    property p_op_tail;
        entValid && ent.kind == ITA_OP && ent.writes == 3'h0 |=> adjOut.tail
            == 10'($past(ent.tail));
    endproperty
    a_op_tail: assert property (p_op_tail) else $error("read op tail moved");
    property p_calc_tail;
        entValid && ent.kind == ITA_EA_CALC |=> adjOut.tail == 10'($past(ent.tail));
    endproperty
    a_calc_tail: assert property (p_calc_tail) else $error("calc tail moved");
    property p_neg_flag;
        totalValid |-> totalNegative == totalCycles[SUM_W-1];
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("sign flag wrong");
endmodule : ita_timing_monitor
